// [rtl/config_word_pkg.sv]
// constants, field layouts and carriers for the configuration word block
// assumes one 50 MHz clock and a synchronous active-high reset
package config_word_pkg;

  localparam int WORD_W = 14;
  localparam int ADDR_W = 16;
  localparam int PM_ADDR_W = 12;

  // word addresses in the configuration space
  localparam logic [15:0] ADDR_USER_ID_FIRST = 16'h8000;
  localparam logic [15:0] ADDR_USER_ID_LAST = 16'h8003;
  localparam logic [15:0] ADDR_STEP = 16'h8005;
  localparam logic [15:0] ADDR_PART = 16'h8006;
  localparam logic [15:0] ADDR_CFG_ONE = 16'h8007;
  localparam logic [15:0] ADDR_CFG_TWO = 16'h8008;
  localparam logic [15:0] ADDR_STATUS = 16'h8010;
  localparam logic [15:0] ADDR_ZC_CTRL = 16'h8011;
  localparam logic [15:0] ADDR_LOCK_CTRL = 16'h8012;
  localparam logic [15:0] ADDR_UNLOCK = 16'h8013;
  localparam logic [15:0] PM_SPACE_LAST = 16'h7fff;

  // configuration word one and two field positions
  localparam int BIT_LVP = 13;
  localparam int BIT_CODE_GUARD_N = 7;
  localparam logic [13:0] UNIMPL_MASK = 14'h0078;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [13:0] ZERO_WORD = 14'h0000;

  // self-write guard codes and protected region ends
  localparam logic [1:0] GUARD_OFF = 2'h3;
  localparam logic [1:0] GUARD_BOOT = 2'h2;
  localparam logic [1:0] GUARD_HALF = 2'h1;
  localparam logic [1:0] GUARD_ALL = 2'h0;
  localparam logic [11:0] GUARD_BOOT_END = 12'h1ff;
  localparam logic [11:0] GUARD_HALF_END = 12'h7ff;

  // pin-map unlock keys, written in order to the unlock register
  localparam logic [7:0] UNLOCK_KEY_A = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_B = 8'haa;

  typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_HALF, UNLOCK_OPEN}
    unlock_state_t;

  typedef struct packed {
    logic low_voltage_program_enable;
    logic tool_mode_io;
    logic low_power_brownout_off;
    logic brownout_level_select;
    logic stack_fault_reset_enable;
    logic clock_multiplier_enable;
    logic zero_cross_force_off;
    logic [3:0] unimpl;
    logic pin_map_one_shot_lock;
    logic [1:0] self_write_guard;
  } cfg_two_fields_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [13:0] wdata;
  } tool_req_t;

endpackage

// [rtl/self_write_guard_decode.sv]
// decides whether a self-write address lies in the guarded region
// assumes guard code held constant between resets
`timescale 1ns/1ps
module self_write_guard_decode
  import config_word_pkg::*;
#(
  parameter int PM_W = PM_ADDR_W
) (
  input wire logic [1:0] guard_code,
  input wire logic [PM_W-1:0] addr,
  output logic guarded
);

  initial begin
    if (PM_W != PM_ADDR_W) $error("only the 4K-word array is served");
  end

  // region end grows as the code falls; all ones guards nothing
  always_comb begin
    unique case (guard_code)
      GUARD_OFF: guarded = 1'b0;
      GUARD_BOOT: guarded = (addr <= GUARD_BOOT_END);
      GUARD_HALF: guarded = (addr <= GUARD_HALF_END);
      GUARD_ALL: guarded = 1'b1;
    endcase
  end

endmodule

// [rtl/pin_map_lock_ctrl.sv]
// pin-map lock with a two-key unlock sequence and one-way option
// assumes writes arrive as one-cycle strobes
`timescale 1ns/1ps
module pin_map_lock_ctrl
  import config_word_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic one_shot,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic lock_wr,
  input wire logic lock_data,
  output logic lock_q,
  output logic open_q
);

  unlock_state_t state_q;

  // any unlock-register write other than a repeated first key, or a lock write, between the keys spoils the sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= UNLOCK_IDLE;
    end else if (lock_wr) begin
      state_q <= UNLOCK_IDLE; // one change per unlock
    end else if (key_wr) begin
      if (key_data == UNLOCK_KEY_A) begin
        state_q <= UNLOCK_HALF;
      end else if (key_data == UNLOCK_KEY_B && state_q == UNLOCK_HALF) begin
        state_q <= UNLOCK_OPEN;
      end else begin
        state_q <= UNLOCK_IDLE;
      end
    end
  end

  // one-way mode never lets a set lock fall again
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (lock_wr && state_q == UNLOCK_OPEN) begin
      if (one_shot) begin
        lock_q <= lock_q | lock_data;
      end else begin
        lock_q <= lock_data;
      end
    end
  end

  assign open_q = (state_q == UNLOCK_OPEN);

endmodule

// [rtl/config_word_protection_ids.sv]
// configuration word two decode, code guard, user and identity words
// assumes a synchronous register port and a tool port in the same domain
//
// Overview of operation
// - bit 13 high allows low-voltage entry; low needs high-voltage entry
// - bit 12 high frees the serial pins; low reserves them for debug
// - bit 11 low enables the low-power brown-out reset
// - bit 10 high picks the low trip level, low the high one
// - bit 9 high lets stack overflow or underflow reset the device
// - bit 8 enables the four-times clock multiplier
// - bit 7 low forces zero-cross on; high leaves it to software
// - bits 6 to 3 read as ones
// - bit 2 high: lock set once after unlock, then blocks pin-map writes
// - bit 2 low: lock set and cleared freely, each after an unlock
// - guard bits protect none, 01ffh, 07ffh or all of 0fffh
// - bit 13 cannot be cleared when entry was by low voltage
// - code guard low blocks tool program-memory access; those tool reads return zeros
// - core reads of program memory are never blocked
// - four user words at 8000h to 8003h, software read and write
// - part word at 8006h, silicon step word at 8005h, 14 bits
// - part and step words are read-only
// - word one at 8007h, word two at 8008h
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module config_word_protection_ids
  import config_word_pkg::*;
#(
  // arbitrary values, not tied to any real part
  parameter logic [13:0] PART_CODE = 14'h0123,
  parameter logic [13:0] STEP_CODE = 14'h0001
) (
  // clock, reset and stored words
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] nv_word_one,
  input wire logic [13:0] nv_word_two,

  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [13:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [13:0] reg_rdata,

  // tool port
  input wire tool_req_t tool_req,
  input wire logic [13:0] pm_tool_rdata,
  output logic [13:0] tool_rdata,
  output logic tool_ack,
  output logic pm_tool_rd,
  output logic pm_tool_wr,
  output logic nv_wr,
  output logic [15:0] nv_wr_addr,
  output logic [13:0] nv_wr_data,

  // entry pins
  input wire logic entry_low_voltage,
  input wire logic entry_high_voltage,
  input wire logic entry_exit,
  output logic prog_mode,
  output logic prog_via_low_voltage,

  // side requests
  input wire logic core_pm_rd_req,
  output logic core_pm_rd_grant,
  input wire logic self_write_req,
  input wire logic [11:0] self_write_addr,
  output logic self_write_grant,
  output logic self_write_refused,
  input wire logic stack_fault,
  output logic stack_reset_req,
  input wire logic pin_map_wr_req,
  output logic pin_map_wr_grant,
  output logic pin_map_lock,

  // decoded levels
  output logic low_voltage_program_enable,
  output logic serial_pins_io,
  output logic low_power_brownout_enable,
  output logic brownout_trip_level_low,
  output logic clock_multiplier_enable,
  output logic zero_cross_enable
);

  logic [13:0] word_one_q;
  logic [13:0] word_two_q;
  cfg_two_fields_t cfg;
  logic [13:0] user_id_q [4];
  logic zero_cross_soft_enable_q;
  logic code_open;
  logic self_guarded;
  logic lock_q;
  logic unlock_open;
  logic [1:0] sw_idx;
  logic [1:0] tool_idx;

  // shared read map for the register port and the tool port
  function automatic logic [13:0] read_word(input logic [15:0] a,
                                            input logic [13:0] w1,
                                            input logic [13:0] w2,
                                            input logic [13:0] ids [4],
                                            input logic zc,
                                            input logic lk,
                                            input logic op);
    logic [13:0] r;
    r = ZERO_WORD;
    if (a >= ADDR_USER_ID_FIRST && a <= ADDR_USER_ID_LAST) begin
      r = ids[a[1:0]];
    end else begin
      unique case (a)
        ADDR_STEP: r = STEP_CODE;
        ADDR_PART: r = PART_CODE;
        ADDR_CFG_ONE: r = w1;
        ADDR_CFG_TWO: r = w2 | UNIMPL_MASK;
        ADDR_STATUS: r = {11'h000, op, lk, zc};
        ADDR_ZC_CTRL: r = {13'h0000, zc};
        ADDR_LOCK_CTRL: r = {13'h0000, lk};
        default: r = ZERO_WORD;
      endcase
    end
    return r;
  endfunction

  // words are caught while reset is held and frozen afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      word_one_q <= nv_word_one;
      word_two_q <= nv_word_two | UNIMPL_MASK;
    end
  end

  assign cfg = cfg_two_fields_t'(word_two_q);
  assign code_open = word_one_q[BIT_CODE_GUARD_N];
  assign sw_idx = reg_addr[1:0];
  assign tool_idx = tool_req.addr[1:0];

  // static decode outputs, registered from the frozen word
  always_ff @(posedge clk) begin
    if (rst) begin
      low_voltage_program_enable <= 1'b1;
      serial_pins_io <= 1'b1;
      low_power_brownout_enable <= 1'b0;
      brownout_trip_level_low <= 1'b1;
      clock_multiplier_enable <= 1'b0;
    end else begin
      low_voltage_program_enable <= cfg.low_voltage_program_enable;
      serial_pins_io <= cfg.tool_mode_io;
      low_power_brownout_enable <= ~cfg.low_power_brownout_off;
      brownout_trip_level_low <= cfg.brownout_level_select;
      clock_multiplier_enable <= cfg.clock_multiplier_enable;
    end
  end

  // stack faults only reach the reset logic when allowed
  always_ff @(posedge clk) begin
    if (rst) begin
      stack_reset_req <= 1'b0;
    end else begin
      stack_reset_req <= stack_fault & cfg.stack_fault_reset_enable;
    end
  end

  // zero-cross software enable and the resulting detector enable
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_cross_soft_enable_q <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_ZC_CTRL) begin
      zero_cross_soft_enable_q <= reg_wdata[0];
    end
  end

  // force-off low beats soft enable
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_cross_enable <= 1'b0;
    end else begin
      zero_cross_enable <= ~cfg.zero_cross_force_off |
                           zero_cross_soft_enable_q;
    end
  end

  // programming entry: low-voltage keys only count when permitted
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_mode <= 1'b0;
      prog_via_low_voltage <= 1'b0;
    end else if (entry_exit) begin
      prog_mode <= 1'b0;
      prog_via_low_voltage <= 1'b0;
    end else if (!prog_mode && entry_high_voltage) begin
      prog_mode <= 1'b1;
      prog_via_low_voltage <= 1'b0;
    end else if (!prog_mode && entry_low_voltage &&
                 cfg.low_voltage_program_enable) begin
      prog_mode <= 1'b1;
      prog_via_low_voltage <= 1'b1;
    end
  end

  // user words: software writes at run time, tools in programming mode
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        user_id_q[i] <= ERASED_WORD;
      end
    end else if (reg_wr && reg_addr >= ADDR_USER_ID_FIRST &&
                 reg_addr <= ADDR_USER_ID_LAST) begin
      user_id_q[sw_idx] <= reg_wdata;
    end else if (prog_mode && tool_req.valid && tool_req.write &&
                 tool_req.addr >= ADDR_USER_ID_FIRST &&
                 tool_req.addr <= ADDR_USER_ID_LAST) begin
      user_id_q[tool_idx] <= tool_req.wdata;
    end
  end

  // register port read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= ZERO_WORD;
    end else if (reg_rd) begin
      reg_rdata <= read_word(reg_addr, word_one_q, word_two_q, user_id_q,
                             zero_cross_soft_enable_q, lock_q, unlock_open);
    end else begin
      reg_rdata <= ZERO_WORD;
    end
  end

  // tool reads: program memory is hidden behind the code guard
  always_ff @(posedge clk) begin
    if (rst) begin
      tool_rdata <= ZERO_WORD;
      tool_ack <= 1'b0;
    end else begin
      tool_ack <= prog_mode & tool_req.valid;
      if (prog_mode && tool_req.valid && !tool_req.write) begin
        if (tool_req.addr <= PM_SPACE_LAST) begin
          tool_rdata <= code_open ? pm_tool_rdata : ZERO_WORD;
        end else begin
          tool_rdata <= read_word(tool_req.addr, word_one_q, word_two_q,
                                  user_id_q, zero_cross_soft_enable_q,
                                  lock_q, unlock_open);
        end
      end else begin
        tool_rdata <= ZERO_WORD;
      end
    end
  end

  // strobes toward the program array, gated by the code guard
  always_ff @(posedge clk) begin
    if (rst) begin
      pm_tool_rd <= 1'b0;
      pm_tool_wr <= 1'b0;
    end else begin
      pm_tool_rd <= prog_mode & tool_req.valid & ~tool_req.write &
                    (tool_req.addr <= PM_SPACE_LAST) & code_open;
      pm_tool_wr <= prog_mode & tool_req.valid & tool_req.write &
                    (tool_req.addr <= PM_SPACE_LAST) & code_open;
    end
  end

  // nonvolatile writes of user and configuration words by the tool;
  // identity words never reach the store
  always_ff @(posedge clk) begin
    if (rst) begin
      nv_wr <= 1'b0;
      nv_wr_addr <= 16'h0000;
      nv_wr_data <= ZERO_WORD;
    end else begin
      nv_wr <= 1'b0;
      if (prog_mode && tool_req.valid && tool_req.write) begin
        nv_wr_addr <= tool_req.addr;
        nv_wr_data <= tool_req.wdata;
        if (tool_req.addr >= ADDR_USER_ID_FIRST &&
            tool_req.addr <= ADDR_USER_ID_LAST) begin
          nv_wr <= 1'b1;
        end else if (tool_req.addr == ADDR_CFG_ONE) begin
          nv_wr <= 1'b1;
        end else if (tool_req.addr == ADDR_CFG_TWO) begin
          nv_wr <= 1'b1;
          // the tool must not lock itself out mid-session
          if (prog_via_low_voltage) begin
            nv_wr_data <= tool_req.wdata | 14'h2000;
          end
        end else if (tool_req.addr == ADDR_STEP ||
                     tool_req.addr == ADDR_PART) begin
          nv_wr <= 1'b0;
        end
      end
    end
  end

  // core fetches and table reads bypass every guard
  always_ff @(posedge clk) begin
    if (rst) begin
      core_pm_rd_grant <= 1'b0;
    end else begin
      core_pm_rd_grant <= core_pm_rd_req;
    end
  end

  // guard code from frozen word
  self_write_guard_decode u_guard (
    .guard_code(cfg.self_write_guard),
    .addr(self_write_addr),
    .guarded(self_guarded)
  );

  // self-write requests split into granted and refused
  always_ff @(posedge clk) begin
    if (rst) begin
      self_write_grant <= 1'b0;
      self_write_refused <= 1'b0;
    end else begin
      self_write_grant <= self_write_req & ~self_guarded;
      self_write_refused <= self_write_req & self_guarded;
    end
  end

  // keys and lock from register port
  pin_map_lock_ctrl u_lock (
    .clk(clk),
    .rst(rst),
    .one_shot(cfg.pin_map_one_shot_lock),
    .key_wr(reg_wr && reg_addr == ADDR_UNLOCK),
    .key_data(reg_wdata[7:0]),
    .lock_wr(reg_wr && reg_addr == ADDR_LOCK_CTRL),
    .lock_data(reg_wdata[0]),
    .lock_q(lock_q),
    .open_q(unlock_open)
  );

  // a set lock stops every pin-map write
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_map_lock <= 1'b0;
      pin_map_wr_grant <= 1'b0;
    end else begin
      pin_map_lock <= lock_q;
      pin_map_wr_grant <= pin_map_wr_req & ~lock_q;
    end
  end

endmodule

// [sim/config_word_checker.sv]
// assertion checker for the configuration word block, bound to its top
// assumes stored words stay stable while reset is high
`timescale 1ns/1ps
module config_word_checker
  import config_word_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] nv_word_one,
  input wire logic [13:0] nv_word_two,
  input wire tool_req_t tool_req,
  input wire logic [13:0] tool_rdata,
  input wire logic tool_ack,
  input wire logic pm_tool_rd,
  input wire logic nv_wr,
  input wire logic [13:0] nv_wr_data,
  input wire logic prog_mode,
  input wire logic prog_via_low_voltage,
  input wire logic core_pm_rd_req,
  input wire logic core_pm_rd_grant,
  input wire logic self_write_req,
  input wire logic [11:0] self_write_addr,
  input wire logic self_write_grant,
  input wire logic self_write_refused,
  input wire logic stack_fault,
  input wire logic stack_reset_req,
  input wire logic pin_map_wr_req,
  input wire logic pin_map_wr_grant,
  input wire logic pin_map_lock,
  input wire logic low_voltage_program_enable,
  input wire logic serial_pins_io,
  input wire logic low_power_brownout_enable,
  input wire logic brownout_trip_level_low,
  input wire logic clock_multiplier_enable,
  input wire logic zero_cross_enable
);
  logic [13:0] w2_q;
  logic guard_d;
  // own copy of word two, taken on every edge in reset like the block's
  always_ff @(posedge clk) begin
    if (rst) w2_q <= nv_word_two;
  end
  // guarded region straight from the guard code
  always_comb begin
    case (w2_q[1:0])
      2'h3: guard_d = 1'b0;
      2'h2: guard_d = self_write_addr <= 12'h1ff;
      2'h1: guard_d = self_write_addr <= 12'h7ff;
      default: guard_d = 1'b1;
    endcase
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ext_rd;
    tool_req.valid && prog_mode && !tool_req.write &&
      tool_req.addr <= PM_SPACE_LAST && !nv_word_one[BIT_CODE_GUARD_N];
  endsequence
  sequence s_id_wr;
    tool_req.valid && prog_mode && tool_req.write &&
      (tool_req.addr == ADDR_STEP || tool_req.addr == ADDR_PART);
  endsequence
  sequence s_lv_cfg_wr;
    tool_req.valid && prog_mode && tool_req.write &&
      tool_req.addr == ADDR_CFG_TWO && prog_via_low_voltage;
  endsequence
  // decode outputs settle one edge after release, hence the past test
  AST_DECODE_LVP: assert property (
    !$past(rst) |-> low_voltage_program_enable == w2_q[13])
    else $error("low voltage enable differs from word two");
  AST_DECODE_DEBUG: assert property (
    !$past(rst) |-> serial_pins_io == w2_q[12])
    else $error("serial pin mode differs from word two");
  AST_DECODE_BOR: assert property (
    !$past(rst) |-> low_power_brownout_enable != w2_q[11])
    else $error("low power brown-out enable wrong");
  AST_DECODE_TRIP: assert property (
    !$past(rst) |-> brownout_trip_level_low == w2_q[10])
    else $error("brown-out trip level wrong");
  AST_DECODE_PLL: assert property (
    !$past(rst) |-> clock_multiplier_enable == w2_q[8])
    else $error("clock multiplier enable wrong");
  AST_ZC_FORCED: assert property (
    !$past(rst) && !w2_q[7] |-> zero_cross_enable)
    else $error("zero cross not forced on");
  AST_STACK_RESET: assert property (
    stack_fault |=> stack_reset_req == w2_q[9])
    else $error("stack fault reset wrong");
  AST_SELF_WRITE: assert property (
    self_write_req |=> self_write_refused == $past(guard_d) &&
      self_write_grant != $past(guard_d))
    else $error("self write guard wrong");
  AST_CORE_READ: assert property (
    core_pm_rd_req |=> core_pm_rd_grant)
    else $error("core read blocked");
  AST_GUARDED_READ: assert property (
    s_ext_rd |=> tool_ack && tool_rdata == 14'h0000 && !pm_tool_rd)
    else $error("guarded tool read leaked");
  AST_ID_READ_ONLY: assert property (
    s_id_wr |=> !nv_wr)
    else $error("identity word written");
  AST_LVP_KEPT: assert property (
    s_lv_cfg_wr |=> nv_wr && nv_wr_data[BIT_LVP])
    else $error("low voltage bit cleared");
  AST_ONE_SHOT: assert property (
    w2_q[2] && pin_map_lock |=> pin_map_lock)
    else $error("one-shot lock cleared");
  AST_LOCK_BLOCKS: assert property (
    pin_map_wr_req && pin_map_lock |=> !pin_map_wr_grant)
    else $error("pin map write passed lock");
endmodule
bind config_word_protection_ids config_word_checker checker_inst (
  .clk, .rst, .nv_word_one, .nv_word_two, .tool_req, .tool_rdata,
  .tool_ack, .pm_tool_rd, .nv_wr, .nv_wr_data, .prog_mode,
  .prog_via_low_voltage, .core_pm_rd_req, .core_pm_rd_grant,
  .self_write_req, .self_write_addr, .self_write_grant,
  .self_write_refused, .stack_fault, .stack_reset_req, .pin_map_wr_req,
  .pin_map_wr_grant, .pin_map_lock, .low_voltage_program_enable,
  .serial_pins_io, .low_power_brownout_enable, .brownout_trip_level_low,
  .clock_multiplier_enable, .zero_cross_enable);

// [sim/tool_model.sv]
// programmer model: issues tool requests and models the array behind them
// assumes op is called from the bench's single stimulus process
`timescale 1ns/1ps
module tool_model
  import config_word_pkg::*;
(
  input wire logic clk,
  output tool_req_t tool_req,
  output logic [13:0] pm_tool_rdata
);
  initial tool_req = '0;
  // array data follow the address; an idle bus shows no real word
  assign pm_tool_rdata = tool_req.valid ? tool_req.addr[13:0] ^ 14'h15a3
    : 14'h2aaa;
  // one request held for exactly one sampled edge
  task automatic op(input logic wr, input logic [15:0] a,
      input logic [13:0] d);
    logic [13:0] v;
    v = d;
    if (a == ADDR_CFG_TWO) v[12] = 1'b1;
    @(posedge clk);
    tool_req <= '{valid: 1'b1, write: wr, addr: a, wdata: v};
    @(posedge clk);
    tool_req <= '0;
    #1;
  endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the configuration word block
// assumes the bound checker and the programmer model beside the block
`timescale 1ns/1ps
module tb;
  import config_word_pkg::*;
  localparam logic [13:0] PART_C = 14'h0246; // arbitrary value
  localparam logic [13:0] STEP_C = 14'h0011; // arbitrary value
  logic clk, rst, reg_wr, reg_rd, tool_ack, pm_tool_rd, pm_tool_wr, nv_wr;
  logic [13:0] nv_word_one, nv_word_two, reg_wdata, reg_rdata, tool_rdata;
  logic [13:0] pm_tool_rdata, nv_wr_data, w;
  logic [15:0] reg_addr, nv_wr_addr;
  logic [11:0] self_write_addr;
  logic entry_low_voltage, entry_high_voltage, entry_exit, prog_mode, g;
  logic prog_via_low_voltage, core_pm_rd_req, core_pm_rd_grant;
  logic self_write_req, self_write_grant, self_write_refused, stack_fault;
  logic stack_reset_req, pin_map_wr_req, pin_map_wr_grant, pin_map_lock;
  logic low_voltage_program_enable, serial_pins_io;
  logic low_power_brownout_enable, brownout_trip_level_low;
  logic clock_multiplier_enable, zero_cross_enable;
  tool_req_t tool_req;
  int errors, checks_done;
  logic [13:0] words [4] = '{14'h2a86, 14'h1501, 14'h3fff, 14'h0000};
  logic [11:0] sw_addr [6] = '{12'h000, 12'h1ff, 12'h200, 12'h7ff,
    12'h800, 12'hfff};
  config_word_protection_ids #(.PART_CODE(PART_C), .STEP_CODE(STEP_C))
    config_word_protection_ids_inst (.clk, .rst, .nv_word_one,
    .nv_word_two, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tool_req, .pm_tool_rdata, .tool_rdata, .tool_ack, .pm_tool_rd,
    .pm_tool_wr, .nv_wr, .nv_wr_addr, .nv_wr_data, .entry_low_voltage,
    .entry_high_voltage, .entry_exit, .prog_mode, .prog_via_low_voltage,
    .core_pm_rd_req, .core_pm_rd_grant, .self_write_req, .self_write_addr,
    .self_write_grant, .self_write_refused, .stack_fault, .stack_reset_req,
    .pin_map_wr_req, .pin_map_wr_grant, .pin_map_lock,
    .low_voltage_program_enable, .serial_pins_io,
    .low_power_brownout_enable, .brownout_trip_level_low,
    .clock_multiplier_enable, .zero_cross_enable);
  tool_model tool_model_inst (.clk, .tool_req, .pm_tool_rdata);
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [13:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data live only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [13:0] exp);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic unlock_then(input logic [13:0] d);
    wr_reg(ADDR_UNLOCK, 14'h0055);
    wr_reg(ADDR_UNLOCK, 14'h00aa);
    wr_reg(ADDR_LOCK_CTRL, d);
    @(posedge clk);
  endtask
  // core, stack, self-write and pin-map requests share one cycle
  task automatic side(input logic [11:0] sa);
    @(posedge clk);
    {stack_fault, core_pm_rd_req, self_write_req, pin_map_wr_req} <= 4'hf;
    self_write_addr <= sa;
    @(posedge clk);
    {stack_fault, core_pm_rd_req, self_write_req, pin_map_wr_req} <= 4'h0;
    #1;
  endtask
  task automatic enter(input logic [2:0] e);
    @(posedge clk);
    {entry_low_voltage, entry_high_voltage, entry_exit} <= e;
    @(posedge clk);
    {entry_low_voltage, entry_high_voltage, entry_exit} <= 3'h0;
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs well under fifty microseconds
  initial begin
    #50000;
    errors++;
    wrap_up();
  end
  initial begin
    {clk, rst, reg_wr, reg_rd, entry_low_voltage, entry_high_voltage} = 6'h10;
    {entry_exit, core_pm_rd_req, self_write_req, stack_fault} = 4'h0;
    {pin_map_wr_req, reg_addr, reg_wdata, self_write_addr} = '0;
    {nv_word_one, nv_word_two, errors, checks_done} = '0;
    for (int i = 0; i < 4; i++) begin
      w = words[i];
      @(posedge clk);
      {rst, nv_word_two} <= {1'b1, w};
      nv_word_one <= i[0] ? 14'h3f7f : 14'h3fff;
      repeat (2) @(posedge clk);
      {rst, nv_word_two} <= {1'b0, ~w};
      repeat (2) @(posedge clk);
      #1 chk("lvp_en", {15'h0, w[13]}, low_voltage_program_enable);
      chk("serial_io", {15'h0, w[12]}, serial_pins_io);
      chk("lp_bor", {15'h0, !w[11]}, low_power_brownout_enable);
      chk("bor_lo", {15'h0, w[10]}, brownout_trip_level_low);
      chk("pll", {15'h0, w[8]}, clock_multiplier_enable);
      chk("zc", {15'h0, !w[7]}, zero_cross_enable);
      wr_reg(ADDR_ZC_CTRL, 14'h0001);
      @(posedge clk);
      #1 chk("zc_soft", 16'h1, zero_cross_enable);
      rd_chk(ADDR_CFG_TWO, w | UNIMPL_MASK);
      rd_chk(ADDR_CFG_ONE, nv_word_one);
      wr_reg(ADDR_PART, 14'h0000);
      wr_reg(ADDR_STEP, 14'h0000);
      rd_chk(ADDR_PART, PART_C);
      rd_chk(ADDR_STEP, STEP_C);
      wr_reg(16'h8004, 14'h3fff);
      rd_chk(16'h8004, 14'h0000);
      for (int k = 0; k < 4; k++) begin
        rd_chk(ADDR_USER_ID_FIRST | 16'(k), ERASED_WORD);
        wr_reg(ADDR_USER_ID_FIRST | 16'(k), 14'h1230 | 14'(k));
        rd_chk(ADDR_USER_ID_FIRST | 16'(k), 14'h1230 | 14'(k));
      end
      foreach (sw_addr[j]) begin
        side(sw_addr[j]);
        g = (w[1:0] == 2'h0) || (w[1:0] == 2'h1 && sw_addr[j] <= 12'h7ff) ||
          (w[1:0] == 2'h2 && sw_addr[j] <= 12'h1ff);
        chk("sw_refused", {15'h0, g}, self_write_refused);
        chk("sw_grant", {15'h0, !g}, self_write_grant);
      end
      chk("stack_reset", {15'h0, w[9]}, stack_reset_req);
      chk("core_grant", 16'h1, core_pm_rd_grant);
      chk("pm_grant", 16'h1, pin_map_wr_grant);
      unlock_then(14'h0001);
      #1 chk("lock_set", 16'h1, pin_map_lock);
      side(12'hfff);
      chk("pm_blocked", 16'h0, pin_map_wr_grant);
      wr_reg(ADDR_LOCK_CTRL, 14'h0000);
      @(posedge clk);
      #1 chk("lock_no_key", 16'h1, pin_map_lock);
      unlock_then(14'h0000);
      #1 chk("lock_clear", {15'h0, w[2]}, pin_map_lock);
      enter(3'b100);
      chk("lv_entry", {15'h0, w[13]}, prog_mode);
      if (!w[13]) enter(3'b010);
      chk("prog_mode", 16'h1, prog_mode);
      tool_model_inst.op(1'b0, 16'h0010, 14'h0000);
      chk("tool_ack", 16'h1, tool_ack);
      chk("tool_rdata", i[0] ? 16'h0 : 16'h15b3, tool_rdata);
      chk("pm_rd", {15'h0, !i[0]}, pm_tool_rd);
      tool_model_inst.op(1'b1, 16'h0010, 14'h0000);
      chk("pm_wr", {15'h0, !i[0]}, pm_tool_wr);
      tool_model_inst.op(1'b1, ADDR_PART, 14'h0000);
      chk("id_store", 16'h0, nv_wr);
      tool_model_inst.op(1'b1, ADDR_CFG_TWO, 14'h0000);
      chk("cfg_wr", 16'h1, nv_wr);
      chk("cfg_data", {2'h0, w[13], 13'h1000}, nv_wr_data);
      chk("cfg_addr", ADDR_CFG_TWO, nv_wr_addr);
      enter(3'b001);
      chk("exit", 16'h0, prog_mode);
    end
    wrap_up();
  end
endmodule
